// ==== sync_and_requantizer_ctrl.sv ====
// Behaviour
// - All sync functions stay inactive unless master sync enable, bit 0, is high.
// - Sync pulses reach the clock divider only while bits 1 and 0 are high.
// - With bit 2 set, divider aligns to first sync pulse, ignores later ones.
// - After a divider sync with bit 2 set, hardware clears the divider sync enable bit.
// - Mode field 000 selects the 22 % passband width.
// - Mode field 001 selects the 33 % passband width.
// - Requantizer runs while control bit 0 is high, off while low.
// - Six-bit tuning word places the requantizer band edges.
// - In 22 % mode only 57 tuning values are valid.
// - In 33 % mode only 34 tuning values are valid.
// - Each tuning step moves the band by 0.5 % of sample rate.
`timescale 1ns/1ns
`default_nettype none
module sync_and_requantizer_ctrl
    import sync_requant_pkg::*;
(
    // Clock and reset
    input  wire logic           sys_clk,
    input  wire logic           resetn,
    // Serial control port
    input  wire logic           sclkPin,
    input  wire logic           csbPin,
    input  wire logic           sdioIn,
    output logic                sdioOut,
    output logic                sdioOeN,
    // External sync
    input  wire logic           syncPin,
    output logic                syncBufferEnable,
    output logic                dividerSyncPulse,
    // Requantizer controls, one set per channel
    output logic [1:0]          requantEnable,
    output logic [1:0]          width33Mode,
    output logic [1:0]          tuningInRange,
    output logic [1:0][5:0]     tuningWord,
    output logic [1:0][6:0]     bandLowEdge,
    output logic [1:0][6:0]     bandHighEdge
);

    reg_bus_if bus ();

    logic [1:0]             syncSync_r;
    logic                   syncDly_r;
    logic                   syncEdge;
    logic [7:0]             syncCtrl_r;
    logic [7:0]             chanIndex_r;
    logic [1:0][7:0]        reqCtrl_r;
    logic [1:0][7:0]        reqTuning_r;
    logic                   syncFire;
    logic                   dividerSync_r;
    logic [1:0]             requantEnable_r;
    logic [1:0]             width33_r;
    logic [1:0]             inRange_r;
    logic [1:0][5:0]        tuningWord_r;
    logic [1:0][6:0]        bandLow_r;
    logic [1:0][6:0]        bandHigh_r;
    logic [7:0]             rdData;

    serial_port_engine port (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .sclkPin (sclkPin),
        .csbPin  (csbPin),
        .sdioIn  (sdioIn),
        .sdioOut (sdioOut),
        .sdioOeN (sdioOeN),
        .bus     (bus.engine)
    );

    function automatic logic is33(input logic [7:0] ctrl);
        return ctrl[REQ_MODE_LSB +: REQ_MODE_W] == MODE_WIDTH_33;
    endfunction

    function automatic logic [5:0] tuningLimit(input logic [7:0] ctrl);
        return is33(ctrl) ? TUNING_MAX_33 : TUNING_MAX_22;
    endfunction

    function automatic logic hits(input logic [12:0] a, input logic [12:0] ofs);
        return bus.wrStb && a == ofs;
    endfunction

    // Sync pin is asynchronous
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            syncSync_r <= 2'h0;
            syncDly_r  <= 1'b0;
        end else begin
            syncSync_r <= {syncSync_r[0], syncPin};
            syncDly_r  <= syncSync_r[1];
        end
    end

    assign syncEdge = syncSync_r[1] & ~syncDly_r;

    // Gate needs both enables
    assign syncFire = syncEdge & syncCtrl_r[SYNC_MASTER_BIT]
                    & syncCtrl_r[SYNC_DIV_EN_BIT];

    // Sync control; a software write in the same cycle wins over the self-clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            syncCtrl_r <= SYNC_CTRL_RST;
        end else if (hits(bus.addr, OFS_SYNC_CTRL)) begin
            syncCtrl_r <= bus.wrData & SYNC_CTRL_MASK;
        end else if (syncFire && syncCtrl_r[SYNC_NEXT_BIT]) begin
            syncCtrl_r[SYNC_DIV_EN_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dividerSync_r <= 1'b0;
        end else begin
            dividerSync_r <= syncFire;
        end
    end

    // Channel index selects which local copies a write reaches
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chanIndex_r <= CHAN_INDEX_RST;
        end else if (hits(bus.addr, OFS_CHAN_INDEX)) begin
            chanIndex_r <= bus.wrData & CHAN_INDEX_MASK;
        end
    end

    // Local requantizer registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int ch = 0; ch < CHAN_COUNT; ch++) begin
                reqCtrl_r[ch]   <= REQ_CTRL_RST;
                reqTuning_r[ch] <= REQ_TUNING_RST;
            end
        end else begin
            for (int ch = 0; ch < CHAN_COUNT; ch++) begin
                if (chanIndex_r[ch] && hits(bus.addr, OFS_REQ_CTRL)) begin
                    reqCtrl_r[ch] <= bus.wrData & REQ_CTRL_MASK;
                end
                if (chanIndex_r[ch] && hits(bus.addr, OFS_REQ_TUNING)) begin
                    reqTuning_r[ch] <= bus.wrData & REQ_TUNING_MASK;
                end
            end
        end
    end

    // Effective settings; an out-of-range word is clamped so the band stays legal
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            requantEnable_r <= 2'h0;
            width33_r       <= 2'h0;
            inRange_r       <= 2'h0;
            tuningWord_r    <= '0;
            bandLow_r       <= '0;
            bandHigh_r      <= '0;
        end else begin
            for (int ch = 0; ch < CHAN_COUNT; ch++) begin
                requantEnable_r[ch] <= reqCtrl_r[ch][REQ_ENABLE_BIT];
                width33_r[ch]       <= is33(reqCtrl_r[ch]);
                inRange_r[ch]       <= reqTuning_r[ch][5:0] <= tuningLimit(reqCtrl_r[ch]);
                if (reqTuning_r[ch][5:0] <= tuningLimit(reqCtrl_r[ch])) begin
                    tuningWord_r[ch] <= reqTuning_r[ch][5:0];
                    bandLow_r[ch]    <= {1'b0, reqTuning_r[ch][5:0]};
                    bandHigh_r[ch]   <= {1'b0, reqTuning_r[ch][5:0]}
                                      + (is33(reqCtrl_r[ch]) ? SPAN_STEPS_33 : SPAN_STEPS_22);
                end else begin
                    tuningWord_r[ch] <= tuningLimit(reqCtrl_r[ch]);
                    bandLow_r[ch]    <= {1'b0, tuningLimit(reqCtrl_r[ch])};
                    bandHigh_r[ch]   <= {1'b0, tuningLimit(reqCtrl_r[ch])}
                                      + (is33(reqCtrl_r[ch]) ? SPAN_STEPS_33 : SPAN_STEPS_22);
                end
            end
        end
    end

    // Read mux; both channels selected reads channel A
    always_comb begin
        rdData = 8'h00;
        if (bus.addr == OFS_SYNC_CTRL) begin
            rdData = syncCtrl_r;
        end else if (bus.addr == OFS_CHAN_INDEX) begin
            rdData = chanIndex_r;
        end else if (bus.addr == OFS_REQ_CTRL) begin
            rdData = chanIndex_r[0] ? reqCtrl_r[0] : reqCtrl_r[1];
        end else if (bus.addr == OFS_REQ_TUNING) begin
            rdData = chanIndex_r[0] ? reqTuning_r[0] : reqTuning_r[1];
        end
    end

    assign bus.rdData       = rdData;
    assign syncBufferEnable = syncCtrl_r[SYNC_MASTER_BIT];
    assign dividerSyncPulse = dividerSync_r;
    assign requantEnable    = requantEnable_r;
    assign width33Mode      = width33_r;
    assign tuningInRange    = inRange_r;
    assign tuningWord       = tuningWord_r;
    assign bandLowEdge      = bandLow_r;
    assign bandHighEdge     = bandHigh_r;

endmodule
`default_nettype wire

// ==== sync_requant_pkg.sv ====
package sync_requant_pkg;

    // Serial port framing
    localparam int          INSTR_BITS     = 16;
    localparam int          ADDR_W         = 13;
    localparam int          DATA_W         = 8;
    localparam logic [3:0]  INSTR_LAST_BIT = 4'hF;
    localparam logic [3:0]  DATA_LAST_BIT  = 4'h7;

    // Register offsets
    localparam logic [12:0] OFS_CHAN_INDEX = 13'h0005;
    localparam logic [12:0] OFS_SYNC_CTRL  = 13'h003A;
    localparam logic [12:0] OFS_REQ_CTRL   = 13'h003C;
    localparam logic [12:0] OFS_REQ_TUNING = 13'h003E;

    // Field positions
    localparam int          SYNC_MASTER_BIT   = 0;
    localparam int          SYNC_DIV_EN_BIT   = 1;
    localparam int          SYNC_NEXT_BIT     = 2;
    localparam int          REQ_ENABLE_BIT    = 0;
    localparam int          REQ_MODE_LSB      = 1;
    localparam int          REQ_MODE_W        = 3;
    localparam int          TUNING_W          = 6;
    localparam int          CHAN_COUNT        = 2;

    // Writable bits per register, everything else reads zero
    localparam logic [7:0]  SYNC_CTRL_MASK  = 8'h07;
    localparam logic [7:0]  REQ_CTRL_MASK   = 8'h0F;
    localparam logic [7:0]  REQ_TUNING_MASK = 8'h3F;
    localparam logic [7:0]  CHAN_INDEX_MASK = 8'h03;

    // Reset values
    localparam logic [7:0]  SYNC_CTRL_RST  = 8'h00;
    localparam logic [7:0]  REQ_CTRL_RST   = 8'h00;
    localparam logic [7:0]  REQ_TUNING_RST = 8'h00;
    localparam logic [7:0]  CHAN_INDEX_RST = 8'h03;

    // Passband modes
    localparam logic [2:0]  MODE_WIDTH_22 = 3'h0;
    localparam logic [2:0]  MODE_WIDTH_33 = 3'h1;

    // Tuning range and band width, in steps of 0.5 % of sample rate
    localparam logic [5:0]  TUNING_MAX_22 = 6'h38;
    localparam logic [5:0]  TUNING_MAX_33 = 6'h21;
    localparam logic [6:0]  SPAN_STEPS_22 = 7'h2C;
    localparam logic [6:0]  SPAN_STEPS_33 = 7'h42;

endpackage

// ==== reg_bus_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface reg_bus_if;
    logic        wrStb;
    logic [12:0] addr;
    logic [7:0]  wrData;
    logic [7:0]  rdData;

    modport engine (
        output wrStb,
        output addr,
        output wrData,
        input  rdData
    );

    modport regs (
        input  wrStb,
        input  addr,
        input  wrData,
        output rdData
    );
endinterface
`default_nettype wire

// ==== serial_port_engine.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_port_engine
    import sync_requant_pkg::*;
(
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    // Serial pins
    input  wire logic   sclkPin,
    input  wire logic   csbPin,
    input  wire logic   sdioIn,
    output logic        sdioOut,
    output logic        sdioOeN,
    // Register access
    reg_bus_if.engine   bus
);

    typedef enum logic {ST_INSTR, ST_DATA} phase_t;

    logic [1:0]        sclkSync_r;
    logic [1:0]        csbSync_r;
    logic [1:0]        sdioSync_r;
    logic              sclkDly_r;
    logic              sclkRise;
    logic              sclkFall;
    logic              csbHigh;
    logic              sdioBit;
    phase_t            phase_r;
    logic [3:0]        bitCnt_r;
    logic [15:0]       shift_r;
    logic              readMode_r;
    logic [12:0]       addr_r;
    logic [12:0]       wrAddr_r;
    logic [7:0]        wrData_r;
    logic              wrStb_r;
    logic              loadPend_r;
    logic [7:0]        txShift_r;
    logic              sdioOut_r;
    logic              sdioOeN_r;

    // Pins are asynchronous to sys_clk; SCLK must stay well below sys_clk / 8
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclkSync_r <= 2'h0;
            csbSync_r  <= 2'h3;
            sdioSync_r <= 2'h0;
            sclkDly_r  <= 1'b0;
        end else begin
            sclkSync_r <= {sclkSync_r[0], sclkPin};
            csbSync_r  <= {csbSync_r[0], csbPin};
            sdioSync_r <= {sdioSync_r[0], sdioIn};
            sclkDly_r  <= sclkSync_r[1];
        end
    end

    assign sclkRise = sclkSync_r[1] & ~sclkDly_r;
    assign sclkFall = ~sclkSync_r[1] & sclkDly_r;
    assign csbHigh  = csbSync_r[1];
    assign sdioBit  = sdioSync_r[1];

    // Instruction and data framing; address walks downward when streaming
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r    <= ST_INSTR;
            bitCnt_r   <= 4'h0;
            shift_r    <= 16'h0000;
            readMode_r <= 1'b0;
            addr_r     <= 13'h0000;
        end else if (csbHigh) begin
            phase_r  <= ST_INSTR;
            bitCnt_r <= 4'h0;
        end else if (sclkRise) begin
            shift_r <= {shift_r[14:0], sdioBit};
            case (phase_r)
                ST_INSTR: begin
                    bitCnt_r <= bitCnt_r + 4'h1;
                    if (bitCnt_r == INSTR_LAST_BIT) begin
                        phase_r    <= ST_DATA;
                        readMode_r <= shift_r[14];
                        addr_r     <= {shift_r[11:0], sdioBit};
                    end
                end
                ST_DATA: begin
                    if (bitCnt_r == DATA_LAST_BIT) begin
                        bitCnt_r <= 4'h0;
                        addr_r   <= addr_r - 13'h0001;
                    end else begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                end
                default: begin
                    phase_r <= ST_INSTR;
                end
            endcase
        end
    end

    // One-cycle write strobe at the last bit of each written byte
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrStb_r  <= 1'b0;
            wrAddr_r <= 13'h0000;
            wrData_r <= 8'h00;
        end else begin
            wrStb_r <= 1'b0;
            if (!csbHigh && sclkRise && phase_r == ST_DATA && bitCnt_r == DATA_LAST_BIT && !readMode_r) begin
                wrStb_r  <= 1'b1;
                wrAddr_r <= addr_r;
                wrData_r <= {shift_r[6:0], sdioBit};
            end
        end
    end

    // Read byte is loaded the cycle after its address settles
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            loadPend_r <= 1'b0;
        end else begin
            loadPend_r <= 1'b0;
            if (!csbHigh && sclkRise) begin
                if (phase_r == ST_INSTR && bitCnt_r == INSTR_LAST_BIT && shift_r[14]) begin
                    loadPend_r <= 1'b1;
                end else if (phase_r == ST_DATA && bitCnt_r == DATA_LAST_BIT && readMode_r) begin
                    loadPend_r <= 1'b1;
                end
            end
        end
    end

    // Read data leaves MSB first, changing on SCLK falling edges
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txShift_r <= 8'h00;
            sdioOut_r <= 1'b0;
            sdioOeN_r <= 1'b1;
        end else begin
            sdioOeN_r <= ~(!csbHigh && phase_r == ST_DATA && readMode_r);
            if (loadPend_r) begin
                txShift_r <= bus.rdData;
            end else if (!csbHigh && sclkFall && phase_r == ST_DATA && readMode_r) begin
                sdioOut_r <= txShift_r[7];
                txShift_r <= {txShift_r[6:0], 1'b0};
            end
        end
    end

    assign bus.wrStb  = wrStb_r;
    assign bus.wrData = wrData_r;
    assign bus.addr   = wrStb_r ? wrAddr_r : addr_r;
    assign sdioOut    = sdioOut_r;
    assign sdioOeN    = sdioOeN_r;

endmodule
`default_nettype wire

// ==== sync_ctrl_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync_ctrl_monitor (
    // Clock and reset
    input wire logic            sys_clk,
    input wire logic            resetn,
    // Watched pins
    input wire logic            csbPin,
    input wire logic            syncPin,
    input wire logic            syncBufferEnable,
    input wire logic            dividerSyncPulse,
    input wire logic [1:0]      requantEnable,
    input wire logic [1:0]      width33Mode,
    input wire logic [1:0]      tuningInRange,
    input wire logic [1:0][5:0] tuningWord,
    input wire logic [1:0][6:0] bandLowEdge,
    input wire logic [1:0][6:0] bandHighEdge
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Outputs settle one edge after release
    logic live_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) live_r <= 1'b0;
        else live_r <= 1'b1;
    end
    sequence s_quiet; csbPin [*8]; endsequence
    sequence s_syncSeen; $past(syncPin, 3) && !$past(syncPin, 4); endsequence
    property p_gate; dividerSyncPulse |-> $past(syncBufferEnable); endproperty
    property p_width; dividerSyncPulse |=> !dividerSyncPulse; endproperty
    property p_cause; dividerSyncPulse |-> s_syncSeen; endproperty
    property p_hold;
        s_quiet |-> $stable(requantEnable) && $stable(width33Mode) && $stable(tuningWord)
            && $stable(syncBufferEnable);
    endproperty
    property p_spanA;
        live_r |-> bandHighEdge[0] == 7'(bandLowEdge[0] + (width33Mode[0] ? 7'h42 : 7'h2C));
    endproperty
    property p_spanB;
        live_r |-> bandHighEdge[1] == 7'(bandLowEdge[1] + (width33Mode[1] ? 7'h42 : 7'h2C));
    endproperty
    property p_clamp;
        live_r |-> tuningWord[0] <= (width33Mode[0] ? 6'h21 : 6'h38)
            && tuningWord[1] <= (width33Mode[1] ? 6'h21 : 6'h38);
    endproperty
    property p_sat;
        live_r && !tuningInRange[0] |-> tuningWord[0] == (width33Mode[0] ? 6'h21 : 6'h38);
    endproperty
    a_gate: assert property (p_gate) else $error("sync pulse while master off");
    a_width: assert property (p_width) else $error("sync pulse too wide");
    a_cause: assert property (p_cause) else $error("sync pulse without edge");
    a_hold: assert property (p_hold) else $error("control moved while port idle");
    a_spanA: assert property (p_spanA) else $error("band span wrong on A");
    a_spanB: assert property (p_spanB) else $error("band span wrong on B");
    a_clamp: assert property (p_clamp) else $error("tuning word above limit");
    a_sat: assert property (p_sat) else $error("out of range word not clamped");
endmodule
`default_nettype wire

// ==== spi_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic  sys_clk,
    // Serial pins
    output logic      sclkPin,
    output logic      csbPin,
    output logic      sdioIn,
    input wire logic  sdioOut,
    input wire logic  sdioOeN
);
    logic hostDrv;
    logic hostBit;
    // Undriven wire toggles so no stale level passes
    assign sdioIn = hostDrv ? hostBit : (!sdioOeN ? sdioOut : sys_clk);
    initial begin
        sclkPin = 1'b0;
        csbPin = 1'b1;
        hostDrv = 1'b1;
        hostBit = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] frame;
        frame = {rd, 2'b00, a, wd};
        q = 8'h00;
        tick(1);
        csbPin = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            hostBit = frame[i];
            tick(8);
            if (rd && i < 8) q[i] = sdioOut;
            sclkPin = 1'b1;
            tick(8);
            sclkPin = 1'b0;
            // Last address bit is sampled by then; the device turns the line around
            if (rd && i == 8) hostDrv = 1'b0;
        end
        tick(8);
        // Port left still between frames
        csbPin = 1'b1;
        hostDrv = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ==== sync_and_requantizer_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync_and_requantizer_ctrl_bench;
    import sync_requant_pkg::*;
    logic            sys_clk, resetn, syncPin, sclkPin, csbPin, sdioIn;
    logic            sdioOut, sdioOeN, syncBufferEnable, dividerSyncPulse;
    logic [1:0]      requantEnable, width33Mode, tuningInRange;
    logic [1:0][5:0] tuningWord;
    logic [1:0][6:0] bandLowEdge, bandHighEdge;
    int              n_errors, num_checks, pulses;
    int              ctlM[2], tunM[2];

    sync_and_requantizer_ctrl i_dut (.sys_clk(sys_clk), .resetn(resetn), .sclkPin(sclkPin),
        .csbPin(csbPin), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOeN(sdioOeN), .syncPin(syncPin),
        .syncBufferEnable(syncBufferEnable), .dividerSyncPulse(dividerSyncPulse),
        .requantEnable(requantEnable), .width33Mode(width33Mode), .tuningInRange(tuningInRange),
        .tuningWord(tuningWord), .bandLowEdge(bandLowEdge), .bandHighEdge(bandHighEdge));
    spi_host_model i_host (.sys_clk(sys_clk), .sclkPin(sclkPin), .csbPin(csbPin),
        .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOeN(sdioOeN));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (dividerSyncPulse === 1'b1) pulses++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b0, a, d, q);
    endtask
    task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_host.xfer(1'b1, a, 8'h00, q);
        check(q, e, "readback");
    endtask
    task automatic syncEdge();
        tick(12);
        syncPin = 1'b1;
        tick(8);
        syncPin = 1'b0;
        tick(12);
    endtask
    task automatic chkOut(input int c);
        int lim;
        int t;
        lim = (((ctlM[c] >> 1) & 7) == 1) ? 33 : 56;
        t = tunM[c] & 63;
        check(8'(requantEnable[c]), 8'(ctlM[c] & 1), "enable");
        check(8'(width33Mode[c]), 8'(lim == 33), "mode");
        check(8'(tuningInRange[c]), 8'(t <= lim), "range");
        check(8'(tuningWord[c]), 8'(t <= lim ? t : lim), "word");
        check({1'b0, bandLowEdge[c]}, 8'(t <= lim ? t : lim), "low edge");
        check({1'b0, 7'(bandHighEdge[c] - bandLowEdge[c])}, 8'(lim == 33 ? 66 : 44), "span");
    endtask

    initial begin
        int lim, tun, ctl, mode, ex;
        n_errors = 0;
        num_checks = 0;
        pulses = 0;
        ctlM = '{0, 0};
        tunM = '{0, 0};
        resetn = 1'b0;
        syncPin = 1'b0;
        void'($urandom(2));
        repeat (10) @(posedge sys_clk);
        #1 resetn = 1'b1;
        tick(2);
        rdchk(OFS_SYNC_CTRL, SYNC_CTRL_RST);
        rdchk(OFS_REQ_CTRL, REQ_CTRL_RST);
        rdchk(OFS_REQ_TUNING, REQ_TUNING_RST);
        rdchk(OFS_CHAN_INDEX, CHAN_INDEX_RST);
        chkOut(0);
        chkOut(1);
        $display("reset test done");
        wr(OFS_SYNC_CTRL, 8'hF8);
        rdchk(OFS_SYNC_CTRL, 8'h00);
        wr(OFS_REQ_CTRL, 8'hF3);
        rdchk(OFS_REQ_CTRL, 8'h03);
        wr(OFS_REQ_TUNING, 8'hE0);
        rdchk(OFS_REQ_TUNING, 8'h20);
        wr(13'h0040, 8'h5A);
        rdchk(13'h0040, 8'h00);
        ctlM = '{3, 3};
        tunM = '{32, 17};
        wr(OFS_CHAN_INDEX, 8'h02);
        wr(OFS_REQ_TUNING, 8'h11);
        rdchk(OFS_REQ_TUNING, 8'h11);
        wr(OFS_CHAN_INDEX, 8'h03);
        rdchk(OFS_REQ_TUNING, 8'h20);
        chkOut(0);
        chkOut(1);
        $display("reserved and channel test done");
        for (int v = 0; v < 8; v++) begin
            wr(OFS_SYNC_CTRL, 8'(v | ($urandom & 'hF8)));
            pulses = 0;
            syncEdge();
            syncEdge();
            ex = ((v & 3) == 3) ? ((v & 4) ? 1 : 2) : 0;
            check(8'(pulses), 8'(ex), "pulses");
            check(8'(syncBufferEnable), 8'(v & 1), "buffer");
            rdchk(OFS_SYNC_CTRL, 8'((v == 7) ? 5 : v));
        end
        // Master off while sync unused
        wr(OFS_SYNC_CTRL, 8'h00);
        $display("sync test done");
        for (int m = 0; m < 3; m++) begin
            mode = (m == 2) ? 6 : m;
            lim = (mode == 1) ? 33 : 56;
            for (int k = 0; k < 4; k++) begin
                // One word past the limit exercises clamping
                tun = (k == 0) ? $urandom_range(lim, 0) : (k == 1) ? lim : (k == 2) ? lim + 1 : 0;
                ctl = (mode << 1) | (k & 1);
                ctlM = '{ctl, ctl};
                tunM = '{tun, tun};
                wr(OFS_REQ_CTRL, 8'(ctl));
                wr(OFS_REQ_TUNING, 8'(tun));
                rdchk(OFS_REQ_CTRL, 8'(ctl));
                rdchk(OFS_REQ_TUNING, 8'(tun));
                chkOut(0);
                chkOut(1);
            end
        end
        $display("requantizer test done");
        close_out();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        close_out();
    end
endmodule

bind sync_and_requantizer_ctrl sync_ctrl_monitor i_mon (.sys_clk(sys_clk), .resetn(resetn),
    .csbPin(csbPin), .syncPin(syncPin), .syncBufferEnable(syncBufferEnable),
    .dividerSyncPulse(dividerSyncPulse), .requantEnable(requantEnable), .width33Mode(width33Mode),
    .tuningInRange(tuningInRange), .tuningWord(tuningWord), .bandLowEdge(bandLowEdge),
    .bandHighEdge(bandHighEdge));
`default_nettype wire
